//--- core/gpio_top.sv
// Purpose: Ports B to E register file with pin toggling and pull-up control
// Assumes: CPU bus gives address, short-I/O flag and one-cycle strobes
// Notes: Read data appears one cycle after the read strobe
// Overview of operation
// - Each port register answers at its data-space offset and, for short I/O, 0x20 lower.
// - A write to a pin-levels register toggles the output latch instead of storing.
// - Every pin has its own direction bit choosing input or output.
// - A direction access by any address view reaches the one real direction register.
// - Output latches and direction registers reset to 0x00, all pins inputs.
// - Port E has pins 2:0 only and its upper bits read as zero.
// - Pin-levels reads return sampled pin levels, not a stored reset constant.
// - With the global pull-up disable set, no port pull-up is enabled.
// - When port E pin 0 is the reset input, its direction, latch and level read zero.
`timescale 1ns/1ns
module gpio_top (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // CPU register access
  input wire logic [7:0] bus_addr,
  input wire logic bus_io_space,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  // Static configuration
  input wire logic reset_pin_mode,
  // Pins, index 0..3 = ports B..E
  input wire logic [gpio_pkg::NUM_PORTS-1:0][7:0] pin_in,
  output logic [gpio_pkg::NUM_PORTS-1:0][7:0] pin_out,
  output logic [gpio_pkg::NUM_PORTS-1:0][7:0] pin_oe,
  output logic [gpio_pkg::NUM_PORTS-1:0][7:0] pin_pullup
);
  import gpio_pkg::*;

  typedef struct packed {
    logic [7:0] rdata;
    logic global_pullup_disable;
    logic rmode_s1;
    logic rmode_s2;
  } gpio_top_s;

  gpio_top_s st_reg;
  gpio_top_s st_next;
  logic [NUM_PORTS-1:0][7:0] rd_pins;
  logic [NUM_PORTS-1:0][7:0] rd_dir;
  logic [NUM_PORTS-1:0][7:0] rd_latch;
  logic [7:0] ds_addr;

  gpio_port_if pif [NUM_PORTS] ();

  ////////////////////////////////////////////////////////////////////////////
  // both address views
  function automatic logic addr_hit(input logic [7:0] a, input logic io,
                                    input logic [7:0] ofs);
    logic hit;
    hit = io ? (a <= IO_SPACE_MAX && 8'(a + IO_OFFSET_SHIFT) == ofs) : (a == ofs);
    return hit;
  endfunction : addr_hit

  ////////////////////////////////////////////////////////////////////////////
  for (genvar k = 0; k < NUM_PORTS; k++) begin : g_port
    localparam int W = (k == PORT_E_INDEX) ? PORT_E_WIDTH : PORT_WIDTH;
    assign pif[k].wdata = bus_wdata;
    assign pif[k].global_pullup_disable = st_reg.global_pullup_disable;
    assign pif[k].wr_pin = bus_wr && addr_hit(bus_addr, bus_io_space,
                                              gpio_reg_ofs(k, GPIO_REG_PIN));
    assign pif[k].wr_dir = bus_wr && addr_hit(bus_addr, bus_io_space,
                                              gpio_reg_ofs(k, GPIO_REG_DIR));
    assign pif[k].wr_latch = bus_wr && addr_hit(bus_addr, bus_io_space,
                                                gpio_reg_ofs(k, GPIO_REG_LATCH));
    assign pif[k].rsv_mask = (k == PORT_E_INDEX) ?
                             (8'(st_reg.rmode_s2) << RESET_PIN_BIT) : 8'h00;
    assign rd_pins[k] = pif[k].pins;
    assign rd_dir[k] = pif[k].dir;
    assign rd_latch[k] = pif[k].latch;

    // port E is three pins wide
    gpio_port #(.WIDTH(W)) u_port (
      .clk(clk),
      .arst_n(arst_n),
      .bus(pif[k].port),
      .pin_in(pin_in[k]),
      .pin_out(pin_out[k]),
      .pin_oe(pin_oe[k]),
      .pin_pullup(pin_pullup[k])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    st_next.rmode_s1 = reset_pin_mode;
    st_next.rmode_s2 = st_reg.rmode_s1;
    if (bus_wr && addr_hit(bus_addr, bus_io_space, OFS_MCU_CTRL)) begin
      st_next.global_pullup_disable = bus_wdata[PULLUP_OFF_BIT];
    end
    if (bus_rd) begin
      // Unmapped addresses read zero
      st_next.rdata = 8'h00;
      if (addr_hit(bus_addr, bus_io_space, OFS_MCU_CTRL)) begin
        st_next.rdata = 8'(st_reg.global_pullup_disable) << PULLUP_OFF_BIT;
      end
      for (int k = 0; k < NUM_PORTS; k++) begin
        if (addr_hit(bus_addr, bus_io_space, gpio_reg_ofs(k, GPIO_REG_PIN))) begin
          st_next.rdata = rd_pins[k];
        end
        if (addr_hit(bus_addr, bus_io_space, gpio_reg_ofs(k, GPIO_REG_DIR))) begin
          st_next.rdata = rd_dir[k];
        end
        if (addr_hit(bus_addr, bus_io_space, gpio_reg_ofs(k, GPIO_REG_LATCH))) begin
          st_next.rdata = rd_latch[k];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.rdata <= RDATA_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus_rdata = st_reg.rdata;

  // Checks below that use ds_addr see both address views as one data-space offset
  assign ds_addr = bus_io_space ? 8'(bus_addr + IO_OFFSET_SHIFT) : bus_addr;

  ////////////////////////////////////////////////////////////////////////////
  property p_io_alias;
    @(posedge clk) disable iff (!arst_n)
    (bus_rd && bus_io_space && bus_addr == 8'(OFS_PORT_C_DIRECTION - IO_OFFSET_SHIFT))
    |=> bus_rdata == $past(rd_dir[1]);
  endproperty
  a_io_alias: assert property (p_io_alias) else $error("short I/O alias read wrong");

  property p_dir_views;
    @(posedge clk) disable iff (!arst_n)
    (bus_wr && !bus_io_space && bus_addr == OFS_PORT_D_DIRECTION)
    ##1 (bus_rd && bus_io_space && bus_addr == 8'(OFS_PORT_D_DIRECTION - IO_OFFSET_SHIFT))
    |=> bus_rdata == $past(bus_wdata, 2);
  endproperty
  a_dir_views: assert property (p_dir_views) else $error("direction views disagree");

  property p_port_e_width;
    @(posedge clk) disable iff (!arst_n)
    (bus_rd && ds_addr >= OFS_PORT_E_PIN_LEVELS
     && ds_addr <= OFS_PORT_E_OUTPUT_LATCH) |=> bus_rdata[7:PORT_E_WIDTH] == '0;
  endproperty
  a_port_e_width: assert property (p_port_e_width) else $error("port E upper bits set");

  property p_reset_pin;
    @(posedge clk) disable iff (!arst_n)
    (bus_rd && st_reg.rmode_s2 && ds_addr >= OFS_PORT_E_PIN_LEVELS
     && ds_addr <= OFS_PORT_E_OUTPUT_LATCH) |=> bus_rdata[RESET_PIN_BIT] == 1'b0;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset pin bit reads one");

  property p_out_needs_oe;
    @(posedge clk) disable iff (!arst_n)
    (pin_out & ~pin_oe) == '0;
  endproperty
  a_out_needs_oe: assert property (p_out_needs_oe) else $error("pin driven while input");

  property p_pu_input_only;
    @(posedge clk) disable iff (!arst_n)
    (pin_pullup & pin_oe) == '0;
  endproperty
  a_pu_input_only: assert property (p_pu_input_only) else $error("pull-up on output");

  property p_port_e_pins;
    @(posedge clk) disable iff (!arst_n)
    ((pin_out[PORT_E_INDEX] | pin_oe[PORT_E_INDEX] | pin_pullup[PORT_E_INDEX])
     >> PORT_E_WIDTH) == 8'h00;
  endproperty
  a_port_e_pins: assert property (p_port_e_pins) else $error("port E upper pins active");

  property p_reset_pin_out;
    @(posedge clk) disable iff (!arst_n)
    st_reg.rmode_s2 |=> !pin_out[PORT_E_INDEX][RESET_PIN_BIT]
      && !pin_oe[PORT_E_INDEX][RESET_PIN_BIT] && !pin_pullup[PORT_E_INDEX][RESET_PIN_BIT];
  endproperty
  a_reset_pin_out: assert property (p_reset_pin_out) else $error("reset pin driven");

  property p_pu_all_off;
    @(posedge clk) disable iff (!arst_n)
    st_reg.global_pullup_disable |=> pin_pullup == '0;
  endproperty
  a_pu_all_off: assert property (p_pu_all_off) else $error("pull-up not disabled");

  property p_pu_ctrl_write;
    @(posedge clk) disable iff (!arst_n)
    (bus_wr && ds_addr == OFS_MCU_CTRL)
    |=> st_reg.global_pullup_disable == $past(bus_wdata[PULLUP_OFF_BIT]);
  endproperty
  a_pu_ctrl_write: assert property (p_pu_ctrl_write) else $error("control write lost");

  property p_dir_c_write;
    @(posedge clk) disable iff (!arst_n)
    (bus_wr && ds_addr == OFS_PORT_C_DIRECTION) |=> pin_oe[1] == $past(bus_wdata);
  endproperty
  a_dir_c_write: assert property (p_dir_c_write) else $error("enable not from direction");

  property p_latch_d_write;
    @(posedge clk) disable iff (!arst_n)
    (bus_wr && ds_addr == OFS_PORT_D_OUTPUT_LATCH)
    |=> pin_out[2] == ($past(bus_wdata) & pin_oe[2]);
  endproperty
  a_latch_d_write: assert property (p_latch_d_write) else $error("output not from latch");

  property p_toggle_b;
    @(posedge clk) disable iff (!arst_n)
    (bus_wr && ds_addr == OFS_PORT_B_PIN_LEVELS)
    |=> (pin_out[0] ^ $past(pin_out[0])) == ($past(bus_wdata) & pin_oe[0]);
  endproperty
  a_toggle_b: assert property (p_toggle_b) else $error("pin write did not toggle");

  property p_pin_read_d;
    @(posedge clk) disable iff (!arst_n)
    (bus_rd && ds_addr == OFS_PORT_D_PIN_LEVELS) |=> bus_rdata == $past(pin_in[2], 3);
  endproperty
  a_pin_read_d: assert property (p_pin_read_d) else $error("pin level read wrong");
endmodule : gpio_top

//--- core/gpio_pkg.sv
// Purpose: Shared constants for the general-purpose I/O port block
// Assumes: Byte-wide CPU data bus, data-space offsets below
// Notes: Port index 0..3 stands for ports B, C, D and E
package gpio_pkg;
  localparam int NUM_PORTS = 4;
  localparam int PORT_WIDTH = 8;
  localparam int PORT_E_WIDTH = 3;
  localparam int PORT_E_INDEX = 3;
  localparam int RESET_PIN_BIT = 0;
  localparam int PULLUP_OFF_BIT = 4;

  // Short I/O view sits this far below the data-space offset
  localparam logic [7:0] IO_OFFSET_SHIFT = 8'h20;
  localparam logic [7:0] IO_SPACE_MAX = 8'h3F;

  localparam logic [7:0] OFS_PORT_B_PIN_LEVELS = 8'h23;
  localparam logic [7:0] OFS_PORT_B_DIRECTION = 8'h24;
  localparam logic [7:0] OFS_PORT_B_OUTPUT_LATCH = 8'h25;
  localparam logic [7:0] OFS_PORT_C_PIN_LEVELS = 8'h26;
  localparam logic [7:0] OFS_PORT_C_DIRECTION = 8'h27;
  localparam logic [7:0] OFS_PORT_C_OUTPUT_LATCH = 8'h28;
  localparam logic [7:0] OFS_PORT_D_PIN_LEVELS = 8'h29;
  localparam logic [7:0] OFS_PORT_D_DIRECTION = 8'h2A;
  localparam logic [7:0] OFS_PORT_D_OUTPUT_LATCH = 8'h2B;
  localparam logic [7:0] OFS_PORT_E_PIN_LEVELS = 8'h2C;
  localparam logic [7:0] OFS_PORT_E_DIRECTION = 8'h2D;
  localparam logic [7:0] OFS_PORT_E_OUTPUT_LATCH = 8'h2E;
  localparam logic [7:0] OFS_MCU_CTRL = 8'h55;

  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  typedef enum logic [1:0] {
    GPIO_REG_PIN = 2'h0,
    GPIO_REG_DIR = 2'h1,
    GPIO_REG_LATCH = 2'h2
  } gpio_reg_e;

  function automatic logic [7:0] gpio_reg_ofs(input int port, input gpio_reg_e kind);
    logic [7:0] ofs;
    ofs = 8'h00;
    case (port)
      0: ofs = (kind == GPIO_REG_PIN) ? OFS_PORT_B_PIN_LEVELS :
               (kind == GPIO_REG_DIR) ? OFS_PORT_B_DIRECTION : OFS_PORT_B_OUTPUT_LATCH;
      1: ofs = (kind == GPIO_REG_PIN) ? OFS_PORT_C_PIN_LEVELS :
               (kind == GPIO_REG_DIR) ? OFS_PORT_C_DIRECTION : OFS_PORT_C_OUTPUT_LATCH;
      2: ofs = (kind == GPIO_REG_PIN) ? OFS_PORT_D_PIN_LEVELS :
               (kind == GPIO_REG_DIR) ? OFS_PORT_D_DIRECTION : OFS_PORT_D_OUTPUT_LATCH;
      default: ofs = (kind == GPIO_REG_PIN) ? OFS_PORT_E_PIN_LEVELS :
               (kind == GPIO_REG_DIR) ? OFS_PORT_E_DIRECTION : OFS_PORT_E_OUTPUT_LATCH;
    endcase
    return ofs;
  endfunction : gpio_reg_ofs
endpackage : gpio_pkg

//--- core/gpio_port_if.sv
// Purpose: Register-side link between the decoder and one port
// Assumes: Eight-bit lanes; narrow ports use the low bits
// Notes: Strobes are one-cycle pulses from the decoder
`timescale 1ns/1ns
interface gpio_port_if;
  logic [7:0] wdata;
  logic wr_pin;
  logic wr_dir;
  logic wr_latch;
  logic global_pullup_disable;
  logic [7:0] rsv_mask;
  logic [7:0] pins;
  logic [7:0] dir;
  logic [7:0] latch;

  modport ctrl (
    output wdata, wr_pin, wr_dir, wr_latch, global_pullup_disable, rsv_mask,
    input pins, dir, latch
  );
  modport port (
    input wdata, wr_pin, wr_dir, wr_latch, global_pullup_disable, rsv_mask,
    output pins, dir, latch
  );
endinterface : gpio_port_if

//--- core/gpio_port.sv
// Purpose: One I/O port: output latch, direction bits, pin sampling
// Assumes: Pins are asynchronous to clk
// Notes: Pin, enable and pull-up outputs are registered
`timescale 1ns/1ns
module gpio_port #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register side
  gpio_port_if.port bus,
  // Pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup
);
  import gpio_pkg::*;

  if (WIDTH < 1 || WIDTH > PORT_WIDTH) begin : g_bad_width
    $error("gpio_port WIDTH out of range");
  end

  typedef struct packed {
    logic [WIDTH-1:0] sync1;
    logic [WIDTH-1:0] sync2;
    logic [WIDTH-1:0] latch;
    logic [WIDTH-1:0] dir;
    logic [WIDTH-1:0] out;
    logic [WIDTH-1:0] oe;
    logic [WIDTH-1:0] pu;
  } gpio_port_s;

  gpio_port_s st_reg;
  gpio_port_s st_next;
  logic [WIDTH-1:0] mask_w;

  assign mask_w = bus.rsv_mask[WIDTH-1:0];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    st_next.sync1 = pin_in[WIDTH-1:0];
    st_next.sync2 = st_reg.sync1;
    if (bus.wr_dir) begin
      st_next.dir = bus.wdata[WIDTH-1:0];
    end
    if (bus.wr_latch) begin
      st_next.latch = bus.wdata[WIDTH-1:0];
    end
    if (bus.wr_pin) begin
      st_next.latch = st_reg.latch ^ bus.wdata[WIDTH-1:0];
    end
    st_next.oe = st_next.dir & ~mask_w;
    st_next.out = st_next.latch & ~mask_w & st_next.dir;
    st_next.pu = ~st_next.dir & st_next.latch & ~mask_w & {WIDTH{~bus.global_pullup_disable}};
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.latch <= LATCH_RST[WIDTH-1:0];
      st_reg.dir <= DIR_RST[WIDTH-1:0];
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unused upper lanes read and drive zero
  assign bus.pins = 8'(st_reg.sync2 & ~mask_w);
  assign bus.dir = 8'(st_reg.dir & ~mask_w);
  assign bus.latch = 8'(st_reg.latch & ~mask_w);
  assign pin_out = 8'(st_reg.out);
  assign pin_oe = 8'(st_reg.oe);
  assign pin_pullup = 8'(st_reg.pu);

  ////////////////////////////////////////////////////////////////////////////
  logic any_write_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      any_write_reg <= 1'b0;
    end else if (bus.wr_pin || bus.wr_dir || bus.wr_latch) begin
      any_write_reg <= 1'b1;
    end
  end

  property p_toggle;
    @(posedge clk) disable iff (!arst_n)
    bus.wr_pin |=> st_reg.latch == ($past(st_reg.latch) ^ $past(bus.wdata[WIDTH-1:0]));
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin write did not toggle latch");

  property p_dir;
    @(posedge clk) disable iff (!arst_n)
    bus.wr_dir |=> ##1 pin_oe[WIDTH-1:0] == ($past(bus.wdata[WIDTH-1:0], 2) & ~$past(mask_w));
  endproperty
  a_dir: assert property (p_dir) else $error("direction write not seen on enable");

  property p_pullup_off;
    @(posedge clk) disable iff (!arst_n)
    bus.global_pullup_disable |=> pin_pullup == 8'h00;
  endproperty
  a_pullup_off: assert property (p_pullup_off) else $error("pull-up active while disabled");

  property p_sample;
    @(posedge clk) disable iff (!arst_n)
    ##2 1'b1 |-> bus.pins[WIDTH-1:0] == ($past(pin_in[WIDTH-1:0], 2) & ~mask_w);
  endproperty
  a_sample: assert property (p_sample) else $error("pin levels not two-stage sampled");

  property p_reset_val;
    @(posedge clk) disable iff (!arst_n)
    !any_write_reg |-> (st_reg.latch == '0 && st_reg.dir == '0 && pin_oe == 8'h00);
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("latch or direction not zero");
endmodule : gpio_port

//--- test/gpio_pin_model.sv
// Purpose: Pin-side partner of the I/O port block
// Assumes: A pin driven by the block wins over any external driver
// Notes: A floating pin without pull-up changes level every cycle
`timescale 1ns/1ns
module gpio_pin_model (
  // Clock
  input wire logic clk,
  // From the block
  input wire logic [3:0][7:0] pin_out,
  input wire logic [3:0][7:0] pin_oe,
  input wire logic [3:0][7:0] pin_pullup,
  // External drivers
  input wire logic [3:0][7:0] ext_val,
  input wire logic [3:0][7:0] ext_en,
  // To the block
  output logic [3:0][7:0] pin_in
);
  logic float_reg = 1'b0;

  // Keeps an undriven line from settling to a value the simulator picks
  always @(posedge clk) begin
    float_reg <= ~float_reg;
  end

  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
      | (~pin_oe & ~ext_en & (pin_pullup | {32{float_reg}}));
  end
endmodule : gpio_pin_model

//--- test/gpio_top_test.sv
// Purpose: Self-checking bench of the I/O port register block
// Assumes: Read data is held until the next read strobe
// Notes: Each bus task access picks the data-space or short I/O view at random
`timescale 1ns/1ns
module gpio_top_test;
  import gpio_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] bus_addr = 8'h00;
  logic bus_io_space = 1'b0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_wdata = 8'h00;
  logic [7:0] bus_rdata;
  logic reset_pin_mode = 1'b0;
  logic [3:0][7:0] pin_in;
  logic [3:0][7:0] pin_out;
  logic [3:0][7:0] pin_oe;
  logic [3:0][7:0] pin_pullup;
  logic [3:0][7:0] ext_val = '0;
  logic [3:0][7:0] ext_en = '1;
  logic [7:0] dir_m [4];
  logic [7:0] lat_m [4];
  logic [7:0] rv;
  int n_errors = 0;
  int tests_run = 0;

  always #2 clk = ~clk;

  gpio_top DUT (.clk(clk), .arst_n(arst_n), .bus_addr(bus_addr), .bus_io_space(bus_io_space),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .reset_pin_mode(reset_pin_mode), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup));

  gpio_pin_model partner (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] ofs(input int p, input int k);
    return OFS_PORT_B_PIN_LEVELS + 8'(3 * p + k);
  endfunction : ofs

  function automatic logic [7:0] pmask(input int p);
    return (p == 3) ? 8'h07 : 8'hFF;
  endfunction : pmask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk

  // One write or read; read data is taken once it has surely landed
  task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] d);
    logic io;
    io = 1'($urandom % 2);
    @(posedge clk);
    #1;
    bus_io_space = io;
    bus_addr = io ? a - IO_OFFSET_SHIFT : a;
    bus_wr = wr;
    bus_rd = ~wr;
    bus_wdata = d;
    @(posedge clk);
    #1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    @(posedge clk);
    #1;
    rv = bus_rdata;
  endtask : bus

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #40000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    int p;
    logic [7:0] t;
    void'($urandom(42));
    repeat (16) @(posedge clk);
    #1;
    arst_n = 1'b1;
    for (int q = 0; q < 4; q++) begin
      bus(ofs(q, 1), 1'b0, 8'h00);
      chk(rv, 8'h00); // direction cleared
      bus(ofs(q, 2), 1'b0, 8'h00);
      chk(rv, 8'h00); // latch cleared
      chk(pin_oe[q], 8'h00); // all pins inputs
    end
    $display("test reset_values done");
    for (int i = 0; i < 40; i++) begin
      p = int'($urandom % 4);
      dir_m[p] = 8'($urandom);
      lat_m[p] = 8'($urandom);
      bus(ofs(p, 1), 1'b1, dir_m[p]);
      bus(ofs(p, 2), 1'b1, lat_m[p]);
      dir_m[p] &= pmask(p);
      lat_m[p] &= pmask(p);
      bus(ofs(p, 1), 1'b0, 8'h00);
      chk(rv, dir_m[p]); // direction readback
      bus(ofs(p, 2), 1'b0, 8'h00);
      chk(rv, lat_m[p]); // latch readback
      chk(pin_oe[p], dir_m[p]); // enable per bit
      chk(pin_out[p], dir_m[p] & lat_m[p]); // output value
      t = 8'($urandom);
      bus(ofs(p, 0), 1'b1, t);
      lat_m[p] ^= t & pmask(p);
      bus(ofs(p, 2), 1'b0, 8'h00);
      chk(rv, lat_m[p]); // toggled latch
      ext_val[p] = 8'($urandom);
      repeat (3) @(posedge clk);
      bus(ofs(p, 0), 1'b0, 8'h00);
      chk(rv, ((dir_m[p] & lat_m[p]) | (~dir_m[p] & ext_val[p])) & pmask(p)); // levels
    end
    bus(8'h30, 1'b0, 8'h00);
    chk(rv, 8'h00); // unmapped reads zero
    $display("test random_access done");
    bus(ofs(0, 1), 1'b1, 8'h00);
    bus(ofs(0, 2), 1'b1, 8'hFF);
    ext_en[0] = 8'h00;
    chk(pin_pullup[0], 8'hFF); // pull-ups on
    bus(OFS_MCU_CTRL, 1'b1, 8'h10);
    chk(pin_pullup[0], 8'h00); // pull-ups off
    bus(OFS_MCU_CTRL, 1'b0, 8'h00);
    chk(rv, 8'h10); // disable bit readback
    $display("test pullup_disable done");
    // Data-space write then short I/O read on the very next cycle
    t = 8'($urandom);
    @(posedge clk);
    #1;
    bus_io_space = 1'b0;
    bus_addr = OFS_PORT_D_DIRECTION;
    bus_wr = 1'b1;
    bus_wdata = t;
    @(posedge clk);
    #1;
    bus_io_space = 1'b1;
    bus_addr = OFS_PORT_D_DIRECTION - IO_OFFSET_SHIFT;
    bus_wr = 1'b0;
    bus_rd = 1'b1;
    @(posedge clk);
    #1;
    bus_rd = 1'b0;
    chk(bus_rdata, t); // views share one register
    chk(pin_oe[2], t); // enable follows direction
    $display("test dir_views done");
    reset_pin_mode = 1'b1;
    bus(ofs(3, 1), 1'b1, 8'hFF);
    bus(ofs(3, 2), 1'b1, 8'hFF);
    repeat (3) @(posedge clk);
    bus(ofs(3, 1), 1'b0, 8'h00);
    chk(rv, 8'h06); // direction bit zero
    bus(ofs(3, 2), 1'b0, 8'h00);
    chk(rv, 8'h06); // latch bit zero
    bus(ofs(3, 0), 1'b0, 8'h00);
    chk(rv, 8'h06); // level bit zero
    chk(pin_oe[3], 8'h06); // reset pin not driven
    reset_pin_mode = 1'b0;
    $display("test reset_pin done");
    arst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    arst_n = 1'b1;
    bus(ofs(3, 1), 1'b0, 8'h00);
    chk(rv, 8'h00); // second reset clears
    $display("test mid_reset done");
    tally_and_finish();
  end
endmodule : gpio_top_test
